// [inc/srm_pkg.sv]
package srm_pkg;

    // ****************************************************************
    // Register offsets (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam logic [7:0] OFS_AUTO_SEL = 8'h00;
    localparam logic [7:0] OFS_DIR_SEL = 8'h04;
    localparam logic [7:0] OFS_REF_CUR = 8'h08;
    localparam logic [7:0] OFS_ACC_RATIO = 8'h0c;
    localparam logic [7:0] OFS_DEC_RATIO = 8'h10;
    localparam logic [7:0] OFS_ACC_TIME = 8'h14;
    localparam logic [7:0] OFS_DEC_TIME = 8'h18;
    localparam logic [7:0] OFS_GEN_STALL = 8'h1c;
    localparam logic [7:0] OFS_USER_GRP = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_TERM_BASE = 8'h30;
    localparam logic [7:0] OFS_TERM_LAST = 8'h40;

    // ****************************************************************
    // Setting codes and limits
    // ****************************************************************
    localparam logic [15:0] SENTINEL = 16'h270f;
    localparam logic [15:0] LIMIT_DEF_PCT = 16'h0096;
    localparam logic [15:0] SEL_NORMAL = 16'h0000;
    localparam logic [15:0] SEL_SHORT = 16'h0001;
    localparam logic [15:0] SEL_SHORT_BRAKE = 16'h000b;
    localparam logic [15:0] SEL_BSEQ1 = 16'h0007;
    localparam logic [15:0] SEL_BSEQ2 = 16'h0008;
    localparam logic [15:0] DIR_BOTH = 16'h0000;
    localparam logic [15:0] DIR_ACCEL = 16'h0001;
    localparam logic [15:0] DIR_DECEL = 16'h0002;
    localparam logic [15:0] REF_MAX = 16'h1388;
    localparam logic [15:0] RATIO_MAX = 16'h00c8;
    localparam logic [31:0] PCT_DIV = 32'h0000_0064;
    localparam logic [15:0] TERM_FUNC_SECOND = 16'h0003;
    localparam int TERM_N = 5;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] RST_TIME = 16'h0032;
    localparam logic [15:0] RST_GEN_STALL = 16'h0096;
    localparam logic [15:0] RST_TERM_FUNC = 16'h0000;
    localparam logic [15:0] RST_ZERO = 16'h0000;

    // ****************************************************************
    // Status register fields
    // ****************************************************************
    localparam int ST_SHORT = 0;
    localparam int ST_BRAKE = 1;
    localparam int ST_BSEQ = 2;
    localparam int ST_SECOND = 3;
    localparam int ST_AUTO = 4;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SHORT,
        MODE_SHORT_BRAKE,
        MODE_BRAKE_SEQ
    } srm_mode_type;

endpackage

// [hw/srm_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the clock domain.
module srm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin side and synchronised side
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// [hw/srm_ramp_ctrl.sv]
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
// How it works
// - Decode mode: 0 normal, 1/11 shortest, 7/8 sequence.
// - Direction: 0 both, 1 accel, 2 decel.
// - Reference current; 9999 means rated current.
// - Accel/decel ratios 0-200%; 9999 means 150%.
// - Ramp limit equals ratio times reference current.
// - General stall level except during auto-rate ramps.
// - Auto rate at ramp start; times untouched.
// - Second function while stopped forces normal ramping.
// - Second function ignored while running auto mode.
// - Mode change restores reference and ratios to 9999.
// - Writes accepted only when user group is 0, bar the group itself.
// - Second function comes from terminal coded 3.
module srm_ramp_ctrl #(
    parameter logic [15:0] RATED_CURRENT = 16'h0032
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Input terminals (pins)
    input wire logic [srm_pkg::TERM_N-1:0] term_i,
    // Ramp generator state
    input wire logic run_i,
    input wire logic accel_i,
    input wire logic decel_i,
    // Ramp control results
    output logic [15:0] stall_level_o,
    output logic auto_rate_o,
    output logic [15:0] accel_time_o,
    output logic [15:0] decel_time_o,
    output logic shortest_o,
    output logic brake_o,
    output logic brake_seq_o,
    output logic second_func_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic ack_q;
    logic [31:0] rdat_q;
    logic [15:0] auto_sel_q;
    logic [15:0] dir_sel_q;
    logic [15:0] ref_cur_q;
    logic [15:0] acc_ratio_q;
    logic [15:0] dec_ratio_q;
    logic [15:0] acc_time_q;
    logic [15:0] dec_time_q;
    logic [15:0] gen_stall_q;
    logic [15:0] user_grp_q;
    logic [15:0] term_func_q [srm_pkg::TERM_N];
    logic [srm_pkg::TERM_N-1:0] term_sync;
    logic second_q;
    logic auto_q;
    logic [15:0] stall_q;
    logic accel_q;
    logic decel_q;
    logic req;
    logic wr;
    logic wr_ok;
    logic [15:0] wdat;
    logic sel_chg;
    logic sf_act;
    srm_pkg::srm_mode_type mode;
    logic mode_short;
    logic eff_short;
    logic dir_acc_ok;
    logic dir_dec_ok;
    logic ramp_start;
    logic [15:0] ref_eff;
    logic [15:0] acc_eff;
    logic [15:0] dec_eff;
    logic [15:0] ratio_sel;
    logic [15:0] base_sel;
    logic [31:0] prod;
    logic [15:0] level_d;
    logic [31:0] status;
    logic term_hit;
    logic [2:0] term_idx;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign req = cyc_i && stb_i && !ack_q;
    assign wr = req && we_i && (sel_i[1:0] == 2'b11);
    assign wdat = dat_i[15:0];
    // The group lock itself stays writable, else it could never open.
    assign wr_ok = wr && ((user_grp_q == srm_pkg::RST_ZERO)
                   || (adr_i == srm_pkg::OFS_USER_GRP));
    assign sel_chg = wr_ok && (adr_i == srm_pkg::OFS_AUTO_SEL)
                     && (wdat != auto_sel_q)
                     && ((wdat == srm_pkg::SEL_NORMAL)
                     || (wdat == srm_pkg::SEL_SHORT)
                     || (wdat == srm_pkg::SEL_SHORT_BRAKE)
                     || (wdat == srm_pkg::SEL_BSEQ1)
                     || (wdat == srm_pkg::SEL_BSEQ2));
    assign term_hit = (adr_i >= srm_pkg::OFS_TERM_BASE)
                      && (adr_i <= srm_pkg::OFS_TERM_LAST)
                      && (adr_i[1:0] == 2'b00);
    assign term_idx = 3'(adr_i[7:2] - srm_pkg::OFS_TERM_BASE[7:2]);
    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    // ****************************************************************
    // Setting registers
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            auto_sel_q <= srm_pkg::SEL_NORMAL;
            dir_sel_q <= srm_pkg::DIR_BOTH;
            ref_cur_q <= srm_pkg::SENTINEL;
            acc_ratio_q <= srm_pkg::SENTINEL;
            dec_ratio_q <= srm_pkg::SENTINEL;
            acc_time_q <= srm_pkg::RST_TIME;
            dec_time_q <= srm_pkg::RST_TIME;
            gen_stall_q <= srm_pkg::RST_GEN_STALL;
            user_grp_q <= srm_pkg::RST_ZERO;
        end
        else if (sel_chg)
        begin
            // Changing mode throws away the tuning values.
            auto_sel_q <= wdat;
            ref_cur_q <= srm_pkg::SENTINEL;
            acc_ratio_q <= srm_pkg::SENTINEL;
            dec_ratio_q <= srm_pkg::SENTINEL;
        end
        else if (wr_ok)
        begin
            unique case (adr_i)
                srm_pkg::OFS_DIR_SEL:
                    if (wdat <= srm_pkg::DIR_DECEL)
                        dir_sel_q <= wdat;
                srm_pkg::OFS_REF_CUR:
                    if (wdat <= srm_pkg::REF_MAX
                        || wdat == srm_pkg::SENTINEL)
                        ref_cur_q <= wdat;
                srm_pkg::OFS_ACC_RATIO:
                    if (wdat <= srm_pkg::RATIO_MAX
                        || wdat == srm_pkg::SENTINEL)
                        acc_ratio_q <= wdat;
                srm_pkg::OFS_DEC_RATIO:
                    if (wdat <= srm_pkg::RATIO_MAX
                        || wdat == srm_pkg::SENTINEL)
                        dec_ratio_q <= wdat;
                srm_pkg::OFS_ACC_TIME:
                    acc_time_q <= wdat;
                srm_pkg::OFS_DEC_TIME:
                    dec_time_q <= wdat;
                srm_pkg::OFS_GEN_STALL:
                    if (wdat <= srm_pkg::RATIO_MAX)
                        gen_stall_q <= wdat;
                srm_pkg::OFS_USER_GRP:
                    user_grp_q <= wdat;
                default:
                begin
                end
            endcase
        end
    end

    // Terminal function codes, one word per terminal.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < srm_pkg::TERM_N; i++)
                term_func_q[i] <= srm_pkg::RST_TERM_FUNC;
        end
        else if (wr_ok && term_hit)
            term_func_q[term_idx] <= wdat;
    end

    // ****************************************************************
    // Read-back
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_q <= '0;
        else if (req && !we_i)
        begin
            rdat_q <= '0;
            unique case (adr_i)
                srm_pkg::OFS_AUTO_SEL: rdat_q[15:0] <= auto_sel_q;
                srm_pkg::OFS_DIR_SEL: rdat_q[15:0] <= dir_sel_q;
                srm_pkg::OFS_REF_CUR: rdat_q[15:0] <= ref_cur_q;
                srm_pkg::OFS_ACC_RATIO: rdat_q[15:0] <= acc_ratio_q;
                srm_pkg::OFS_DEC_RATIO: rdat_q[15:0] <= dec_ratio_q;
                srm_pkg::OFS_ACC_TIME: rdat_q[15:0] <= acc_time_q;
                srm_pkg::OFS_DEC_TIME: rdat_q[15:0] <= dec_time_q;
                srm_pkg::OFS_GEN_STALL: rdat_q[15:0] <= gen_stall_q;
                srm_pkg::OFS_USER_GRP: rdat_q[15:0] <= user_grp_q;
                srm_pkg::OFS_STATUS: rdat_q <= status;
                default:
                    if (term_hit)
                        rdat_q[15:0] <= term_func_q[term_idx];
            endcase
        end
    end

    // ****************************************************************
    // Second function input
    // ****************************************************************
    srm_sync #(
        .WIDTH(srm_pkg::TERM_N)
    ) u_term_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(term_i),
        .sync_o(term_sync)
    );

    always_comb
    begin
        sf_act = 1'b0;
        for (int i = 0; i < srm_pkg::TERM_N; i++)
            if (term_func_q[i] == srm_pkg::TERM_FUNC_SECOND)
                sf_act = sf_act | term_sync[i];
    end

    // The input is only looked at while stopped, so a change during
    // a run cannot swap the limits in the middle of a ramp.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            second_q <= 1'b0;
        else if (!run_i)
            second_q <= sf_act;
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    always_comb
    begin
        unique case (auto_sel_q)
            srm_pkg::SEL_SHORT: mode = srm_pkg::MODE_SHORT;
            srm_pkg::SEL_SHORT_BRAKE: mode = srm_pkg::MODE_SHORT_BRAKE;
            srm_pkg::SEL_BSEQ1, srm_pkg::SEL_BSEQ2:
                mode = srm_pkg::MODE_BRAKE_SEQ;
            default: mode = srm_pkg::MODE_NORMAL;
        endcase
    end

    assign mode_short = (mode == srm_pkg::MODE_SHORT)
                        || (mode == srm_pkg::MODE_SHORT_BRAKE);
    assign eff_short = mode_short && !second_q;
    assign dir_acc_ok = (dir_sel_q != srm_pkg::DIR_DECEL);
    assign dir_dec_ok = (dir_sel_q != srm_pkg::DIR_ACCEL);
    assign ramp_start = (accel_i && !accel_q) || (decel_i && !decel_q);

    // ****************************************************************
    // Automatic rate adjust
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            accel_q <= 1'b0;
            decel_q <= 1'b0;
        end
        else
        begin
            accel_q <= accel_i;
            decel_q <= decel_i;
        end
    end

    // The decision is made once per ramp and held to its end.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            auto_q <= 1'b0;
        else if (!eff_short)
            auto_q <= 1'b0;
        else if (ramp_start)
            auto_q <= (accel_i && dir_acc_ok)
                      || (decel_i && dir_dec_ok);
        else if (!accel_i && !decel_i)
            auto_q <= 1'b0;
    end

    // ****************************************************************
    // Stall prevention level
    // ****************************************************************
    assign ref_eff = (ref_cur_q == srm_pkg::SENTINEL)
                     ? RATED_CURRENT : ref_cur_q;
    assign acc_eff = (acc_ratio_q == srm_pkg::SENTINEL)
                     ? srm_pkg::LIMIT_DEF_PCT : acc_ratio_q;
    assign dec_eff = (dec_ratio_q == srm_pkg::SENTINEL)
                     ? srm_pkg::LIMIT_DEF_PCT : dec_ratio_q;

    // One shared multiplier; the ramp limit and the general level
    // never apply at the same time.
    always_comb
    begin
        ratio_sel = gen_stall_q;
        base_sel = RATED_CURRENT;
        if (auto_q && accel_i)
        begin
            ratio_sel = acc_eff;
            base_sel = ref_eff;
        end
        else if (auto_q && decel_i)
        begin
            ratio_sel = dec_eff;
            base_sel = ref_eff;
        end
    end

    assign prod = 32'(ratio_sel) * 32'(base_sel);
    assign level_d = 16'(prod / srm_pkg::PCT_DIV);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stall_q <= srm_pkg::RST_ZERO;
        else
            stall_q <= level_d;
    end

    // ****************************************************************
    // Outputs and status
    // ****************************************************************
    assign stall_level_o = stall_q;
    assign auto_rate_o = auto_q;
    assign accel_time_o = acc_time_q;
    assign decel_time_o = dec_time_q;
    assign shortest_o = eff_short;
    assign brake_o = eff_short && (mode == srm_pkg::MODE_SHORT_BRAKE);
    assign brake_seq_o = (mode == srm_pkg::MODE_BRAKE_SEQ);
    assign second_func_o = second_q;

    always_comb
    begin
        status = '0;
        status[srm_pkg::ST_SHORT] = eff_short;
        status[srm_pkg::ST_BRAKE] = brake_o;
        status[srm_pkg::ST_BSEQ] = brake_seq_o;
        status[srm_pkg::ST_SECOND] = second_q;
        status[srm_pkg::ST_AUTO] = auto_q;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_restore_refs: assert property (@(posedge clk_i) disable iff (rst_i)
        sel_chg |=> (ref_cur_q == srm_pkg::SENTINEL)
        && (acc_ratio_q == srm_pkg::SENTINEL)
        && (dec_ratio_q == srm_pkg::SENTINEL))
        else $error("Mode change did not restore tuning values.");

    a_lock_writes: assert property (@(posedge clk_i) disable iff (rst_i)
        (user_grp_q != srm_pkg::RST_ZERO) |=> $stable(ref_cur_q)
        && $stable(auto_sel_q) && $stable(acc_time_q))
        else $error("Setting changed while writes were locked.");

    a_second_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run_i && mode_short) ##1 (!run_i && sf_act)
        |=> !shortest_o && !auto_rate_o)
        else $error("Second function while stopped kept auto mode.");

    a_second_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_i && !second_q) |=> !second_q)
        else $error("Second function taken during a run.");

    a_auto_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (eff_short && accel_i && !accel_q && dir_acc_ok)
        |=> auto_rate_o || !eff_short)
        else $error("Shortest ramp started without auto rate.");

    a_dir_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (auto_rate_o && accel_i && !decel_i)
        |-> (dir_sel_q != srm_pkg::DIR_DECEL))
        else $error("Auto rate on an excluded direction.");

    a_normal_ramp: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == srm_pkg::MODE_NORMAL) |=> !auto_rate_o)
        else $error("Auto rate active in normal mode.");

    a_ramp_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (auto_rate_o && accel_i) |=> stall_level_o ==
        16'((32'($past(acc_eff)) * 32'($past(ref_eff))) / srm_pkg::PCT_DIV))
        else $error("Ramp stall level is not ratio times reference.");

    a_const_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_i && !accel_i && !decel_i) |=> stall_level_o ==
        16'((32'($past(gen_stall_q)) * 32'(RATED_CURRENT))
        / srm_pkg::PCT_DIV))
        else $error("Constant speed did not use the general level.");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("Bus acknowledge not a single cycle.");

endmodule

// [test/srm_motor_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Motor and ramp generator seen from the control block
// ****************************************************************
// Speed steps one unit a cycle toward the target, so a ramp lasts as
// many cycles as the speed difference; a long ramp keeps checks easy.
module srm_motor_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Target speed
    input wire logic [7:0] target_i,
    // Ramp state
    output logic run_o,
    output logic accel_o,
    output logic decel_o
);
    logic [7:0] speed_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            speed_q <= 8'h00;
        else if (speed_q < target_i)
            speed_q <= speed_q + 8'h01;
        else if (speed_q > target_i)
            speed_q <= speed_q - 8'h01;
    end

    assign accel_o = speed_q < target_i;
    assign decel_o = speed_q > target_i;
    assign run_o = (speed_q != 8'h00) || (target_i != 8'h00);
endmodule

// [test/srm_ramp_ctrl_tb.sv]
`timescale 1ns/1ps
// ****************************************************************
// Testbench
// ****************************************************************
module srm_ramp_ctrl_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o;
    logic ack_o, run, acc, dec, auto_rate_o, shortest_o, brake_o;
    logic brake_seq_o, second_func_o;
    logic [4:0] term = 5'h00;
    logic [7:0] tgt = 8'h00;
    logic [15:0] stall_level_o, accel_time_o, decel_time_o;
    logic [31:0] rd;
    int num_errors = 0;
    int n_tests = 0;

    always #2 clk_i = ~clk_i;

    srm_ramp_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .term_i(term), .run_i(run),
        .accel_i(acc), .decel_i(dec), .stall_level_o(stall_level_o),
        .auto_rate_o(auto_rate_o), .accel_time_o(accel_time_o),
        .decel_time_o(decel_time_o), .shortest_o(shortest_o),
        .brake_o(brake_o), .brake_seq_o(brake_seq_o),
        .second_func_o(second_func_o));

    srm_motor_model motor (.clk_i(clk_i), .rst_i(rst_i), .target_i(tgt),
        .run_o(run), .accel_o(acc), .decel_o(dec));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The request is held until ack is seen high at a rising edge; read
    // data is taken at that same edge and only then is the bus freed.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
        @(posedge clk_i);
        chk("ack_idle", 32'h0, {31'h0, ack_o});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {16'h0000, d};
        do
        begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        chk(nm, {16'h0000, e}, rd);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Starts a ramp, checks its rate mode and limit, then the level
    // at constant speed once the ramp is over.
    task automatic ramp(input logic [7:0] t, input logic ea,
                        input logic [15:0] es);
        @(posedge clk_i);
        tgt <= t;
        waitc(3);
        chk("auto_rate", {31'h0, ea}, {31'h0, auto_rate_o});
        chk("stall_ramp", {16'h0, es}, {16'h0, stall_level_o});
        chk("accel_time", 32'h32, {16'h0, accel_time_o});
        chk("decel_time", 32'h32, {16'h0, decel_time_o});
        waitc(30);
        chk("auto_end", 32'h0, {31'h0, auto_rate_o});
        chk("stall_const", 32'h4b, {16'h0, stall_level_o});
    endtask

    task automatic test_reset();
        rdchk("auto_sel", srm_pkg::OFS_AUTO_SEL, 16'h0000);
        rdchk("dir_sel", srm_pkg::OFS_DIR_SEL, 16'h0000);
        rdchk("ref", srm_pkg::OFS_REF_CUR, srm_pkg::SENTINEL);
        rdchk("acc_r", srm_pkg::OFS_ACC_RATIO, srm_pkg::SENTINEL);
        rdchk("dec_r", srm_pkg::OFS_DEC_RATIO, srm_pkg::SENTINEL);
        rdchk("acc_t", srm_pkg::OFS_ACC_TIME, srm_pkg::RST_TIME);
        rdchk("gen", srm_pkg::OFS_GEN_STALL, srm_pkg::RST_GEN_STALL);
        rdchk("unmapped", 8'hfc, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_modes();
        logic [15:0] code [4];
        logic [2:0] exp [4];
        code = '{16'h0001, 16'h000b, 16'h0007, 16'h0000};
        exp = '{3'b100, 3'b110, 3'b001, 3'b000};
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, srm_pkg::OFS_AUTO_SEL, code[i]);
            waitc(2);
            chk("mode_out", {29'h0, exp[i]},
                {29'h0, shortest_o, brake_o, brake_seq_o});
        end
        $display("test modes done");
    endtask

    task automatic test_restore();
        wb(1'b1, srm_pkg::OFS_AUTO_SEL, 16'h0001);
        wb(1'b1, srm_pkg::OFS_REF_CUR, 16'h0064);
        wb(1'b1, srm_pkg::OFS_ACC_RATIO, 16'h0078);
        wb(1'b1, srm_pkg::OFS_DEC_RATIO, 16'h0050);
        rdchk("ref_set", srm_pkg::OFS_REF_CUR, 16'h0064);
        wb(1'b1, srm_pkg::OFS_AUTO_SEL, 16'h000b);
        rdchk("ref_rst", srm_pkg::OFS_REF_CUR, srm_pkg::SENTINEL);
        rdchk("acc_rst", srm_pkg::OFS_ACC_RATIO, srm_pkg::SENTINEL);
        rdchk("dec_rst", srm_pkg::OFS_DEC_RATIO, srm_pkg::SENTINEL);
        $display("test restore done");
    endtask

    task automatic test_limits();
        wb(1'b1, srm_pkg::OFS_AUTO_SEL, 16'h0001);
        wb(1'b1, srm_pkg::OFS_REF_CUR, 16'h0064);
        wb(1'b1, srm_pkg::OFS_ACC_RATIO, 16'h0078);
        ramp(8'd20, 1'b1, 16'h0078);
        ramp(8'd0, 1'b1, 16'h0096);
        wb(1'b1, srm_pkg::OFS_REF_CUR, srm_pkg::SENTINEL);
        ramp(8'd20, 1'b1, 16'h003c);
        ramp(8'd0, 1'b1, 16'h004b);
        $display("test limits done");
    endtask

    task automatic test_dirs();
        wb(1'b1, srm_pkg::OFS_DIR_SEL, srm_pkg::DIR_ACCEL);
        ramp(8'd20, 1'b1, 16'h003c);
        ramp(8'd0, 1'b0, 16'h004b);
        wb(1'b1, srm_pkg::OFS_DIR_SEL, srm_pkg::DIR_DECEL);
        ramp(8'd20, 1'b0, 16'h004b);
        ramp(8'd0, 1'b1, 16'h004b);
        wb(1'b1, srm_pkg::OFS_DIR_SEL, srm_pkg::DIR_BOTH);
        $display("test dirs done");
    endtask

    task automatic test_lock();
        wb(1'b1, srm_pkg::OFS_USER_GRP, 16'h0001);
        wb(1'b1, srm_pkg::OFS_REF_CUR, 16'h00c8);
        rdchk("ref_locked", srm_pkg::OFS_REF_CUR, srm_pkg::SENTINEL);
        wb(1'b1, srm_pkg::OFS_USER_GRP, 16'h0000);
        wb(1'b1, srm_pkg::OFS_REF_CUR, 16'h1389);
        rdchk("ref_range", srm_pkg::OFS_REF_CUR, srm_pkg::SENTINEL);
        $display("test lock done");
    endtask

    task automatic test_second();
        wb(1'b1, srm_pkg::OFS_TERM_BASE, srm_pkg::TERM_FUNC_SECOND);
        @(posedge clk_i);
        term <= 5'h02;
        waitc(5);
        chk("wrong_term", 32'h0, {31'h0, second_func_o});
        ramp(8'd20, 1'b1, 16'h003c);
        @(posedge clk_i);
        term <= 5'h01;
        waitc(5);
        chk("second_run", 32'h0, {31'h0, second_func_o});
        chk("short_run", 32'h1, {31'h0, shortest_o});
        @(posedge clk_i);
        tgt <= 8'd0;
        waitc(30);
        chk("second_stop", 32'h1, {31'h0, second_func_o});
        chk("short_stop", 32'h0, {31'h0, shortest_o});
        rdchk("status", srm_pkg::OFS_STATUS, 16'h0008);
        @(posedge clk_i);
        term <= 5'h00;
        $display("test second done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_modes();
        test_restore();
        test_limits();
        test_dirs();
        test_lock();
        test_second();
        summarize();
    end

    initial
    begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule
